// file: hw/fcd_map.vh
// Overview of operation
// - Complement pattern inverts addressed file register, updates zero
// - Destination bit 0 to working, 1 to file
// - Decrement pattern subtracts one, routes result, updates zero
// - Decrement-and-skip subtracts one, leaves flags unchanged
// - Zero result cancels prefetched word, runs no-operation
// - Every word takes two cycles, a skipped word too; single word
`ifndef FCD_MAP_VH
`define FCD_MAP_VH
// Opcode patterns on bits 11:6 of the instruction word
`define FCD_OPC_HI            11
`define FCD_OPC_LO            6
`define FCD_OPC_COMPLEMENT    6'h09
`define FCD_OPC_DECREMENT     6'h03
`define FCD_OPC_DEC_SKIP      6'h0B
// Operand field positions
`define FCD_DEST_BIT          5
`define FCD_ADDR_HI           4
`define FCD_ADDR_LO           0
// Reset values
`define FCD_W_RESET           8'h00
`define FCD_Z_RESET           1'b0
`define FCD_NOP_WORD          12'h000
`endif

// file: hw/fcd_file_mem.v
`timescale 1ns/100ps
// File register memory, registered read port
module fcd_file_mem #(
    parameter AW = 5,
    parameter DW = 8
) (
    // Clock
    input  wire          i_clk,
    input  wire          i_ce,
    // Read port
    input  wire [AW-1:0] i_raddr,
    output reg  [DW-1:0] o_rdata,
    // Write port
    input  wire          i_we,
    input  wire [AW-1:0] i_waddr,
    input  wire [DW-1:0] i_wdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // No reset on storage, like real file registers
    always @(posedge i_clk) begin
        if (i_ce) begin
            if (i_we) begin
                mem[i_waddr] <= i_wdata;
            end
            o_rdata <= mem[i_raddr];
        end
    end
endmodule

// file: hw/fcd_core.v
`timescale 1ns/100ps
`include "fcd_map.vh"
// Executes complement, decrement and decrement-skip-zero file operations.
// Each accepted word passes a fetch phase (operand read) then an execute
// phase (write back); a skip turns the following word into a no-operation.
// The operand memory has a registered read port, so the read address is
// steered from the offered word while idle; that buys one clean register
// stage on the read path at the cost of one idle cycle per word.
// Limitation: a debug load aimed at the same cycle as a file write back
// is lost, since the execute write owns the single write port.
// Words with any other opcode pass through execute as no-operations.
module fcd_core #(
    parameter AW = 5,
    parameter DW = 8
) (
    // Clock and reset
    input  wire          i_clk,
    input  wire          i_rst,
    input  wire          i_ce,
    // Instruction stream
    input  wire          i_valid,
    input  wire [11:0]   i_instr,
    // Debug write port into the file registers
    input  wire          i_load,
    input  wire [AW-1:0] i_load_addr,
    input  wire [DW-1:0] i_load_data,
    // State out
    output reg  [DW-1:0] o_w,
    output reg           o_zero,
    output reg           o_skip,
    output reg           o_done,
    output wire [DW-1:0] o_file_rdata
);
    // One-hot sequencer states
    localparam ST_IDLE = 2'b01;
    localparam ST_EXEC = 2'b10;

    // Width of the opcode field above the destination bit
    localparam OPC_W = `FCD_OPC_HI - `FCD_OPC_LO + 1;

    // Sequencer state and the word under execution
    reg  [1:0]       state;
    reg  [1:0]       next_state;
    reg  [11:0]      cur_instr;
    reg  [11:0]      next_cur_instr;
    reg              skip_pend;
    reg              next_skip_pend;

    // Next values of the visible state
    reg  [DW-1:0]    next_w;
    reg              next_zero;
    reg              next_skip;
    reg              next_done;

    // Operand path
    wire [DW-1:0]    rdata;
    wire [DW-1:0]    comp_res;
    wire [DW-1:0]    dec_res;
    reg  [DW-1:0]    result;

    // Decode of the word under execution
    wire [OPC_W-1:0] opc;
    wire             dest;
    wire [AW-1:0]    addr;
    wire [AW-1:0]    raddr;
    wire             is_comp;
    wire             is_dec;
    wire             is_dsz;
    wire             is_known;
    wire             in_idle;
    wire             in_exec;
    wire             take;
    wire             zres;

    // Shared write port of the file registers
    wire             file_we;
    wire             mem_we;
    wire [AW-1:0]    mem_waddr;
    wire [DW-1:0]    mem_wdata;

    // Registered read data goes straight out
    assign o_file_rdata = rdata;

    // Field extraction from the held word
    assign opc  = cur_instr[`FCD_OPC_HI:`FCD_OPC_LO];
    assign dest = cur_instr[`FCD_DEST_BIT];
    assign addr = cur_instr[`FCD_ADDR_HI:`FCD_ADDR_LO];

    // State decode; a word is only taken while idle
    assign in_idle = (state == ST_IDLE);
    assign in_exec = (state == ST_EXEC);
    assign take    = in_idle && i_valid;

    // Opcode decode; anything else runs as a no-operation
    assign is_comp  = (opc == `FCD_OPC_COMPLEMENT);
    assign is_dec   = (opc == `FCD_OPC_DECREMENT);
    assign is_dsz   = (opc == `FCD_OPC_DEC_SKIP);
    assign is_known = is_comp || is_dec || is_dsz;

    // Offered word addresses the memory while idle, so the operand
    // is already registered when execute starts
    assign raddr = in_idle ? i_instr[`FCD_ADDR_HI:`FCD_ADDR_LO] : addr;

    // Complement, one inverter per data bit
    genvar gi;
    generate
        for (gi = 0; gi < DW; gi = gi + 1) begin : g_comp
            assign comp_res[gi] = ~rdata[gi];
        end
    endgenerate

    // Decrement wraps from zero to all ones
    assign dec_res = rdata - {{(DW-1){1'b0}}, 1'b1};

    // Result select; both decrements share one subtractor
    always @* begin
        if (is_comp) begin
            result = comp_res;
        end else begin
            result = dec_res;
        end
    end

    // Zero detect feeds the flag and the skip decision
    assign zres = (result == {DW{1'b0}});

    // Write back to the file only for a known op with destination 1
    assign file_we = in_exec && dest && is_known;

    // Debug load shares the write port; execute write has priority
    assign mem_we    = file_we || i_load;
    assign mem_waddr = file_we ? addr : i_load_addr;
    assign mem_wdata = file_we ? result : i_load_data;

    // File register storage
    fcd_file_mem #(
        .AW(AW),
        .DW(DW)
    ) u_mem (
        .i_clk   (i_clk),
        .i_ce    (i_ce),
        .i_raddr (raddr),
        .o_rdata (rdata),
        .i_we    (mem_we),
        .i_waddr (mem_waddr),
        .i_wdata (mem_wdata)
    );

    // Next values of sequencer, working register and flags
    always @* begin
        next_state     = state;
        next_cur_instr = cur_instr;
        next_skip_pend = skip_pend;
        next_w         = o_w;
        next_zero      = o_zero;
        next_skip      = 1'b0;
        next_done      = 1'b0;
        case (state)
            ST_IDLE: begin
                if (take) begin
                    // Prefetched word dropped on a pending skip
                    next_cur_instr = skip_pend ? `FCD_NOP_WORD : i_instr;
                    next_skip      = skip_pend;
                    next_skip_pend = 1'b0;
                    next_state     = ST_EXEC;
                end
            end
            ST_EXEC: begin
                // Destination 0 steers the result to the working register
                if (is_known && !dest) begin
                    next_w = result;
                end
                // Skip variant leaves the zero flag alone
                if (is_comp || is_dec) begin
                    next_zero = zres;
                end
                // Skip is held until the next word is taken, however late
                if (is_dsz && zres) begin
                    next_skip_pend = 1'b1;
                end
                next_done  = 1'b1;
                next_state = ST_IDLE;
            end
            default: begin
                // Illegal code recovers to idle
                next_state = ST_IDLE;
            end
        endcase
    end

    // State registers; a low clock enable freezes everything
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state     <= ST_IDLE;
            cur_instr <= `FCD_NOP_WORD;
            skip_pend <= 1'b0;
            o_w       <= `FCD_W_RESET;
            o_zero    <= `FCD_Z_RESET;
            o_skip    <= 1'b0;
            o_done    <= 1'b0;
        end else if (i_ce) begin
            state     <= next_state;
            cur_instr <= next_cur_instr;
            skip_pend <= next_skip_pend;
            o_w       <= next_w;
            o_zero    <= next_zero;
            o_skip    <= next_skip;
            o_done    <= next_done;
        end
    end
endmodule

// file: dv/fcd_core_checker.sv
`timescale 1ns/100ps
// Operand shows on read data during execute, so a finished word is judged against it
module fcd_core_checker #(
    parameter AW = 5,
    parameter DW = 8
) (
    input wire          i_clk,
    input wire          i_rst,
    input wire          i_valid,
    input wire [11:0]   i_instr,
    input wire [DW-1:0] o_w,
    input wire          o_zero,
    input wire          o_skip,
    input wire          o_done,
    input wire [DW-1:0] o_file_rdata
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Opcode and destination of the word now finishing, two edges back
    wire [6:0] op = i_instr[11:5];
    property p_complement_file_op; o_done && !$past(o_skip) && $past(op, 2) == 7'h12
        |-> o_w == ~$past(o_file_rdata) && o_zero == (o_w == 8'h00); endproperty
    a_complement_file_op: assert property (p_complement_file_op) else $error("complement result wrong");
    property p_dest; o_done && $past(i_instr[5], 2) |-> $stable(o_w); endproperty
    a_dest: assert property (p_dest) else $error("file destination touched working reg");
    property p_dec; o_done && !$past(o_skip) && $past(op, 2) == 7'h06
        |-> o_w == $past(o_file_rdata) - 8'h01 && o_zero == (o_w == 8'h00); endproperty
    a_dec: assert property (p_dec) else $error("decrement result wrong");
    property p_dsz; o_done && $past(i_instr[11:6], 2) == 6'h0B |-> $stable(o_zero); endproperty
    a_dsz: assert property (p_dsz) else $error("skip decrement changed zero flag");
    property p_skip; o_skip |-> $stable(o_w) && $stable(o_zero); endproperty
    a_skip: assert property (p_skip) else $error("discarded word changed state");
    property p_pulse; o_done |=> !o_done; endproperty
    a_pulse: assert property (p_pulse) else $error("done wider than one cycle");
    property p_take; o_done |-> $past(i_valid, 2); endproperty
    a_take: assert property (p_take) else $error("done without an offered word");
endmodule
bind fcd_core fcd_core_checker #(.AW(AW), .DW(DW)) u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_valid(i_valid),
    .i_instr(i_instr), .o_w(o_w), .o_zero(o_zero), .o_skip(o_skip), .o_done(o_done), .o_file_rdata(o_file_rdata));

// file: dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    reg         i_clk = 1'b0;
    reg         i_rst = 1'b1;
    reg         i_valid = 1'b0;
    reg  [11:0] i_instr = 12'h000;
    reg         i_load = 1'b0;
    reg  [4:0]  i_load_addr = 5'h00;
    reg  [7:0]  i_load_data = 8'h00;
    wire [7:0]  o_w;
    wire [7:0]  o_file_rdata;
    wire        o_zero;
    wire        o_skip;
    wire        o_done;
    int         err_count = 0;
    int         total_checks = 0;
    logic       sk;
    always #10 i_clk = ~i_clk;
    // Clock enable held high; freezing is not exercised here
    fcd_core DUT (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_valid(i_valid), .i_instr(i_instr), .i_load(i_load),
        .i_load_addr(i_load_addr), .i_load_data(i_load_data), .o_w(o_w), .o_zero(o_zero), .o_skip(o_skip),
        .o_done(o_done), .o_file_rdata(o_file_rdata));
    task end_sim;
        if (err_count == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
            err_count++;
        end
    endtask
    task ld(input logic [4:0] a, input logic [7:0] d);
        @(posedge i_clk) {i_load, i_load_addr, i_load_data} <= {1'b1, a, d};
        @(posedge i_clk) i_load <= 1'b0;
    endtask
    // Word held until done so the checker sees it; skip pulse is collected on the way
    task ex(input logic [11:0] w);
        @(posedge i_clk) {i_valid, i_instr} <= {1'b1, w};
        @(posedge i_clk) i_valid <= 1'b0;
        // Skip pulse stands only in the cycle after the take edge
        #1 sk = o_skip;
        repeat (4) begin
            @(posedge i_clk) #1 sk = sk | o_skip;
            if (o_done === 1'b1) return;
        end
        err_count++;
        end_sim;
    endtask
    // Idle read data follows the address field one edge late
    task rd(input logic [4:0] a, input logic [7:0] e);
        @(posedge i_clk) i_instr <= {7'h00, a};
        @(posedge i_clk) #1 chk(o_file_rdata, e);
    endtask
    task t_complement_file_op;
        ld(5'h03, 8'h13);
        ex(12'h243); chk(o_w, 8'hEC); chk({7'h00, o_zero}, 8'h00);
        ex(12'h263); rd(5'h03, 8'hEC);
    endtask
    task t_dec;
        ld(5'h04, 8'h01);
        ex(12'h0E4); chk({7'h00, o_zero}, 8'h01);
        rd(5'h04, 8'h00);
        ex(12'h0C4); chk(o_w, 8'hFF); chk({7'h00, o_zero}, 8'h00);
    endtask
    task t_dsz;
        ld(5'h05, 8'h02);
        ex(12'h2E5); chk({7'h00, sk}, 8'h00); rd(5'h05, 8'h01);
        ex(12'h2E5); chk({7'h00, o_zero}, 8'h00);
        ex(12'h243); chk({7'h00, sk}, 8'h01); chk(o_w, 8'hFF); rd(5'h05, 8'h00);
    endtask
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        t_complement_file_op;
        t_dec;
        t_dsz;
        end_sim;
    end
endmodule
